/* inband_loop_pkg.sv */
// Constants, carriers and length decoders for the in-band loop code
// generator and its three receive detectors.
// Assumes a 250 MHz system clock and a T1 line rate of 1544 kbit/s.
// Operation
// R1: Transmit length code 00,01,10,11 decode 5,6/3,7,16.
// R2: Transmit pattern high bit 7 goes first.
// R3: Short transmit lengths ignore low high-register bits.
// R4: Transmit low register is low byte, 16-bit only.
// R5: Up detector: bit 7 first, unused bits ignored.
// R6: Up detector ignores low register below 8 bits.
// R7: Down detector: bit 7 first, unused bits ignored.
// R8: Down detector ignores low register below 8 bits.
// R9: Writing a detector high register restarts integration.
// R10: Spare length 000-110 gives 1-7, 111 gives 16.
// R11: Host writes zero to spare length bits 3-7.
// R12: Spare detector: bit 7 first, unused bits ignored.
// R13: Spare detector ignores low register below 8 bits.
// R14: Send pattern when enabled; framing bit every 193.
// R15: Flag sets after about 36 ms valid code.
// R16: Host loads 8-bit codes twice, 16-bit as pair.
// R17: Generation and detection run only in T1 mode.
// R18: High register is high byte, sent/compared first.
package inband_loop_pkg;

  // -------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'hb6;
  localparam logic [7:0] TX_HI_ADDR  = 8'hb7;
  localparam logic [7:0] TX_LO_ADDR  = 8'hb8;
  localparam logic [7:0] UP_HI_ADDR  = 8'hb9;
  localparam logic [7:0] UP_LO_ADDR  = 8'hba;
  localparam logic [7:0] DN_HI_ADDR  = 8'hbb;
  localparam logic [7:0] DN_LO_ADDR  = 8'hbc;
  localparam logic [7:0] EX_LEN_ADDR = 8'hbd;
  localparam logic [7:0] EX_HI_ADDR  = 8'hbe;
  localparam logic [7:0] EX_LO_ADDR  = 8'hbf;
  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Field positions in the code control, spare length and pattern registers
  localparam int TX_LEN_MSB = 7;
  localparam int TX_LEN_LSB = 6;
  localparam int UP_LEN_MSB = 5;
  localparam int UP_LEN_LSB = 3;
  localparam int DN_LEN_MSB = 2;
  localparam int DN_LEN_LSB = 0;
  localparam int EX_LEN_MSB = 2;
  localparam int PAT_MSB    = 15;

  // -------------------------------------------------------------
  // Lengths and timing
  // -------------------------------------------------------------
  localparam logic [4:0] TX_LEN_C0   = 5'd5;
  localparam logic [4:0] TX_LEN_C1   = 5'd6;
  localparam logic [4:0] TX_LEN_C2   = 5'd7;
  localparam logic [4:0] LEN_LONG    = 5'd16;
  localparam logic [2:0] RX_LONG_SEL = 3'h7;
  localparam int FRAME_BITS    = 193;
  localparam int CLK_MHZ       = 250;
  localparam int INTEG_TIME_MS = 36;
  localparam int LINE_KBPS     = 1544;
  localparam int BER_DIVISOR   = 100;
  localparam int INTEG_CYCLES_DEF = INTEG_TIME_MS * CLK_MHZ * 1000;
  localparam int INTEG_BITS    = INTEG_TIME_MS * LINE_KBPS;
  localparam int MAX_ERR_DEF   = INTEG_BITS / BER_DIVISOR;
  localparam int MIN_MATCH_DEF = INTEG_BITS - MAX_ERR_DEF;

  // -------------------------------------------------------------
  // Carriers
  // -------------------------------------------------------------
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic [15:0] pattern;
    logic [2:0]  len_code;
  } det_cfg_type;

  // Transmit length; 6/3 and 16/8/4/2/1 share one period
  function automatic logic [4:0] tx_len(input logic [1:0] code);
    unique case (code)
      2'h0:    tx_len = TX_LEN_C0;
      2'h1:    tx_len = TX_LEN_C1;
      2'h2:    tx_len = TX_LEN_C2;
      default: tx_len = LEN_LONG;
    endcase
  endfunction : tx_len

  // Receive length; 8-bit codes run as 16 with doubled bytes
  function automatic logic [4:0] rx_len(input logic [2:0] code);
    if (code == RX_LONG_SEL) begin
      rx_len = LEN_LONG;
    end else begin
      rx_len = {2'h0, code} + 5'd1;
    end
  endfunction : rx_len

endpackage : inband_loop_pkg

/* loop_code_generator.sv */
// Serial loop code generator for the transmit bit stream.
// Assumes the framer pulses tx_bit_strobe once per line bit.
`timescale 1ns/1ps
module loop_code_generator import inband_loop_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        active,
  input  wire logic [15:0] pattern,
  input  wire logic [1:0]  len_code,
  input  wire logic        fbit_insert_disable,
  input  wire logic        tx_bit_strobe,
  input  wire logic        tx_fbit_value,
  output logic             tx_data_q
);

  logic [4:0] len;
  logic [3:0] ptr_q;
  logic [7:0] fcnt_q;
  logic       fslot;

  assign len   = tx_len(len_code); // R1
  assign fslot = (fcnt_q == 8'h00) && !fbit_insert_disable;

  // -------------------------------------------------------------
  // Pattern pointer; restarts at bit 15 whenever idle
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= 4'h0;
    end else if (!active) begin
      ptr_q <= 4'h0; // R2
    end else if ({1'b0, ptr_q} >= len) begin
      // A length shortened mid-run restarts the repetition
      ptr_q <= 4'h0;
    end else if (tx_bit_strobe) begin
      // Short lengths wrap early so low bits never go out
      if ({1'b0, ptr_q} == len - 5'd1) begin // R3 R4
        ptr_q <= 4'h0;
      end else begin
        ptr_q <= ptr_q + 4'h1;
      end
    end
  end

  // Frame position; the pattern keeps running under the F-bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fcnt_q <= 8'h00;
    end else if (!active) begin
      fcnt_q <= 8'h00;
    end else if (tx_bit_strobe) begin
      if (fcnt_q == 8'(FRAME_BITS - 1)) begin // R14
        fcnt_q <= 8'h00;
      end else begin
        fcnt_q <= fcnt_q + 8'h01;
      end
    end
  end

  // Output bit: high byte first, F-bit overwrites
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_data_q <= 1'b0;
    end else if (!active) begin
      tx_data_q <= 1'b0;
    end else if (tx_bit_strobe) begin
      tx_data_q <= fslot ? tx_fbit_value // R14
                         : pattern[PAT_MSB - ptr_q]; // R18
    end
  end

  sequence s_fslot_bit;
    active && tx_bit_strobe && fslot;
  endsequence

  a_tx_fbit_slot: assert property (@(posedge sys_clk) disable iff (rst) // R14
    s_fslot_bit |=> tx_data_q == $past(tx_fbit_value))
    else $error("framing bit not sent in its slot");
  a_tx_first_bit: assert property (@(posedge sys_clk) disable iff (rst) // R2
    active && tx_bit_strobe && !fslot && ptr_q == 4'h0
    |=> tx_data_q == $past(pattern[PAT_MSB]))
    else $error("pattern repetition did not start with bit 15");
  a_tx_ptr_wrap: assert property (@(posedge sys_clk) disable iff (rst) // R1
    $stable(len_code) |-> {1'b0, ptr_q} < len)
    else $error("transmit pointer beyond selected length");

endmodule : loop_code_generator

/* loop_code_detector.sv */
// One repeating-pattern detector with a timed integration window.
// Assumes rx_bit_strobe marks each received line bit, framed or not.
`timescale 1ns/1ps
module loop_code_detector import inband_loop_pkg::*; #(
  parameter int INTEG_CYCLES = INTEG_CYCLES_DEF,
  parameter int MAX_ERR      = MAX_ERR_DEF,
  parameter int MIN_MATCH    = MIN_MATCH_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        enable,
  input  wire logic        restart,
  input  wire det_cfg_type cfg,
  input  wire logic        rx_bit_strobe,
  input  wire logic        rx_bit,
  output logic             seen_flag_q
);

  localparam int WW = $clog2(INTEG_CYCLES + 1);

  if (INTEG_CYCLES < 2 || MAX_ERR < 0 || MIN_MATCH >= 65535)
    $error("detector window parameters out of range");

  logic [4:0]    len;
  logic [3:0]    ptr_q;
  logic [WW-1:0] win_q;
  logic [15:0]   err_q;
  logic [15:0]   match_q;
  logic          win_end;
  logic          miss;
  logic          clr;

  assign len     = rx_len(cfg.len_code); // R10
  assign miss    = rx_bit != cfg.pattern[PAT_MSB - ptr_q]; // R18
  assign win_end = win_q == WW'(INTEG_CYCLES - 1);
  assign clr     = restart || !enable;

  // -------------------------------------------------------------
  // Phase hunt: a miss holds the pointer so it slides into line
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_q <= 4'h0;
    end else if (clr) begin
      ptr_q <= 4'h0;
    end else if ({1'b0, ptr_q} >= len) begin
      // A length shortened mid-hunt must not leave the pointer past it
      ptr_q <= 4'h0;
    end else if (rx_bit_strobe && !miss) begin
      // Wrap before the low byte unless length is 16
      if ({1'b0, ptr_q} == len - 5'd1) begin // R5 R6 R7 R8 R12 R13
        ptr_q <= 4'h0;
      end else begin
        ptr_q <= ptr_q + 4'h1;
      end
    end
  end

  // Integration window timer, restarted by a high register write
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_q <= '0;
    end else if (clr || win_end) begin
      win_q <= '0; // R9
    end else begin
      win_q <= win_q + WW'(1);
    end
  end

  // Error and match tallies saturate rather than wrap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_q   <= 16'h0000;
      match_q <= 16'h0000;
    end else if (clr || win_end) begin
      err_q   <= 16'h0000; // R9
      match_q <= 16'h0000;
    end else if (rx_bit_strobe) begin
      if (miss && err_q != 16'hffff) begin
        err_q <= err_q + 16'h0001;
      end else if (!miss && match_q != 16'hffff) begin
        match_q <= match_q + 16'h0001;
      end
    end
  end

  // Verdict at each window end; tolerates about one error in 100
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seen_flag_q <= 1'b0;
    end else if (!enable) begin
      seen_flag_q <= 1'b0; // R17
    end else if (win_end) begin
      seen_flag_q <= err_q <= 16'(MAX_ERR) && // R15
                     match_q >= 16'(MIN_MATCH);
    end
  end

  a_det_restart_zero: assert property (@(posedge sys_clk) // R9
    disable iff (rst) restart |=> win_q == '0 && err_q == 16'h0000)
    else $error("restart did not clear integration");
  a_det_flag_window: assert property (@(posedge sys_clk) // R15
    disable iff (rst) $rose(seen_flag_q) |-> $past(win_end))
    else $error("flag rose outside a window end");
  a_det_off_clear: assert property (@(posedge sys_clk) // R17
    disable iff (rst) !enable |=> !seen_flag_q)
    else $error("flag held while not in T1 mode");
  a_det_short_mask: assert property (@(posedge sys_clk) // R6
    disable iff (rst) $stable(cfg.len_code) && cfg.len_code != RX_LONG_SEL
    |-> ptr_q < 4'h8)
    else $error("short code reached low register");

endmodule : loop_code_detector

/* inband_loop_code_regs.sv */
// Register file of the in-band loop code function, with the
// transmit generator and the up, down and spare detectors.
// Assumes the host port and bit strobes are synchronous to sys_clk;
// mode and enable bits arrive as plain levels from the framer.
`timescale 1ns/1ps
module inband_loop_code_regs import inband_loop_pkg::*; #(
  parameter int INTEG_CYCLES = INTEG_CYCLES_DEF,
  parameter int MAX_ERR      = MAX_ERR_DEF,
  parameter int MIN_MATCH    = MIN_MATCH_DEF
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire host_req_type host_req,
  output logic [7:0]        rd_data_q,
  input  wire logic         t1_mode,
  input  wire logic         tx_loopcode_enable,
  input  wire logic         fbit_insert_disable,
  input  wire logic         tx_bit_strobe,
  input  wire logic         tx_fbit_value,
  output logic              tx_data_q,
  output logic              tx_code_active_q,
  input  wire logic         rx_bit_strobe,
  input  wire logic         rx_bit,
  output logic              up_code_seen_flag,
  output logic              down_code_seen_flag,
  output logic              third_code_seen_flag
);

  if (INTEG_CYCLES < 2 || MIN_MATCH < 0)
    $error("integration parameters out of range");

  // -------------------------------------------------------------
  // Definition and control registers
  // -------------------------------------------------------------
  logic [7:0] inband_code_control_q;
  logic [7:0] tx_pattern_high_q;
  logic [7:0] tx_pattern_low_q;
  logic [7:0] loopup_pattern_high_q;
  logic [7:0] loopup_pattern_low_q;
  logic [7:0] loopdown_pattern_high_q;
  logic [7:0] loopdown_pattern_low_q;
  logic [7:0] extra_detector_length_q;
  logic [7:0] extra_pattern_high_q;
  logic [7:0] extra_pattern_low_q;

  logic        wr;
  logic        up_restart;
  logic        dn_restart;
  logic        ex_restart;
  logic        active_d;
  det_cfg_type up_cfg;
  det_cfg_type dn_cfg;
  det_cfg_type ex_cfg;
  logic [7:0]  rd_d;
  logic        unmapped;

  assign wr = host_req.wr_en;

  // Host writes; each register is a plain byte store
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      inband_code_control_q   <= REG_RESET;
      tx_pattern_high_q       <= REG_RESET;
      tx_pattern_low_q        <= REG_RESET;
      loopup_pattern_high_q   <= REG_RESET;
      loopup_pattern_low_q    <= REG_RESET;
      loopdown_pattern_high_q <= REG_RESET;
      loopdown_pattern_low_q  <= REG_RESET;
      extra_detector_length_q <= REG_RESET;
      extra_pattern_high_q    <= REG_RESET;
      extra_pattern_low_q     <= REG_RESET;
    end else if (wr) begin
      unique case (host_req.addr)
        CTRL_ADDR:   inband_code_control_q   <= host_req.wdata;
        TX_HI_ADDR:  tx_pattern_high_q       <= host_req.wdata;
        TX_LO_ADDR:  tx_pattern_low_q        <= host_req.wdata;
        UP_HI_ADDR:  loopup_pattern_high_q   <= host_req.wdata;
        UP_LO_ADDR:  loopup_pattern_low_q    <= host_req.wdata;
        DN_HI_ADDR:  loopdown_pattern_high_q <= host_req.wdata;
        DN_LO_ADDR:  loopdown_pattern_low_q  <= host_req.wdata;
        // Upper bits are stored as written; software keeps them 0
        EX_LEN_ADDR: extra_detector_length_q <= host_req.wdata; // R11
        EX_HI_ADDR:  extra_pattern_high_q    <= host_req.wdata;
        EX_LO_ADDR:  extra_pattern_low_q     <= host_req.wdata;
        default:     ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Read path; unmapped addresses answer zero
  // -------------------------------------------------------------
  always_comb begin
    rd_d     = UNMAPPED_RD;
    unmapped = 1'b0;
    unique case (host_req.addr)
      CTRL_ADDR:   rd_d = inband_code_control_q;
      TX_HI_ADDR:  rd_d = tx_pattern_high_q;
      TX_LO_ADDR:  rd_d = tx_pattern_low_q;
      UP_HI_ADDR:  rd_d = loopup_pattern_high_q;
      UP_LO_ADDR:  rd_d = loopup_pattern_low_q;
      DN_HI_ADDR:  rd_d = loopdown_pattern_high_q;
      DN_LO_ADDR:  rd_d = loopdown_pattern_low_q;
      EX_LEN_ADDR: rd_d = extra_detector_length_q;
      EX_HI_ADDR:  rd_d = extra_pattern_high_q;
      EX_LO_ADDR:  rd_d = extra_pattern_low_q;
      default:     unmapped = 1'b1;
    endcase
  end

  // Read data is held until the next read strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= UNMAPPED_RD;
    end else if (host_req.rd_en) begin
      rd_data_q <= rd_d;
    end
  end

  // -------------------------------------------------------------
  // Transmit side
  // -------------------------------------------------------------
  assign active_d = t1_mode && tx_loopcode_enable; // R14 R17

  // Registered so the generator sees a clean level
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_code_active_q <= 1'b0;
    end else begin
      tx_code_active_q <= active_d;
    end
  end

  loop_code_generator u_gen (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .active              (tx_code_active_q),
    .pattern             ({tx_pattern_high_q,
                           tx_pattern_low_q}), // R4 R18
    .len_code            (inband_code_control_q[TX_LEN_MSB:
                                                TX_LEN_LSB]),
    .fbit_insert_disable (fbit_insert_disable),
    .tx_bit_strobe       (tx_bit_strobe),
    .tx_fbit_value       (tx_fbit_value),
    .tx_data_q           (tx_data_q)
  );

  // -------------------------------------------------------------
  // Receive detectors
  // -------------------------------------------------------------
  // Restart strobes follow a write of each high register
  assign up_restart = wr && host_req.addr == UP_HI_ADDR; // R9
  assign dn_restart = wr && host_req.addr == DN_HI_ADDR; // R9
  assign ex_restart = wr && host_req.addr == EX_HI_ADDR; // R9

  // High byte leads; 8-bit codes rely on both bytes matching
  assign up_cfg = '{pattern:  {loopup_pattern_high_q,
                               loopup_pattern_low_q}, // R16
                    len_code: inband_code_control_q[UP_LEN_MSB:
                                                    UP_LEN_LSB]};
  assign dn_cfg = '{pattern:  {loopdown_pattern_high_q,
                               loopdown_pattern_low_q},
                    len_code: inband_code_control_q[DN_LEN_MSB:
                                                    DN_LEN_LSB]};
  // Only the low three length bits steer the spare detector
  assign ex_cfg = '{pattern:  {extra_pattern_high_q,
                               extra_pattern_low_q},
                    len_code: extra_detector_length_q[EX_LEN_MSB:0]};

  loop_code_detector #(
    .INTEG_CYCLES (INTEG_CYCLES),
    .MAX_ERR      (MAX_ERR),
    .MIN_MATCH    (MIN_MATCH)
  ) u_up_det (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .enable        (t1_mode), // R17
    .restart       (up_restart),
    .cfg           (up_cfg),
    .rx_bit_strobe (rx_bit_strobe),
    .rx_bit        (rx_bit),
    .seen_flag_q   (up_code_seen_flag)
  );

  loop_code_detector #(
    .INTEG_CYCLES (INTEG_CYCLES),
    .MAX_ERR      (MAX_ERR),
    .MIN_MATCH    (MIN_MATCH)
  ) u_dn_det (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .enable        (t1_mode), // R17
    .restart       (dn_restart),
    .cfg           (dn_cfg),
    .rx_bit_strobe (rx_bit_strobe),
    .rx_bit        (rx_bit),
    .seen_flag_q   (down_code_seen_flag)
  );

  loop_code_detector #(
    .INTEG_CYCLES (INTEG_CYCLES),
    .MAX_ERR      (MAX_ERR),
    .MIN_MATCH    (MIN_MATCH)
  ) u_ex_det (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .enable        (t1_mode), // R17
    .restart       (ex_restart),
    .cfg           (ex_cfg),
    .rx_bit_strobe (rx_bit_strobe),
    .rx_bit        (rx_bit),
    .seen_flag_q   (third_code_seen_flag)
  );

  // -------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------
  sequence s_rd_unmapped;
    host_req.rd_en && unmapped;
  endsequence

  a_rd_unmapped_zero: assert property (@(posedge sys_clk)
    disable iff (rst) s_rd_unmapped |=> rd_data_q == UNMAPPED_RD)
    else $error("unmapped read not answered with zero");
  a_tx_enable_gate: assert property (@(posedge sys_clk) // R14
    disable iff (rst) !(t1_mode && tx_loopcode_enable)
    |=> !tx_code_active_q ##1 !tx_data_q)
    else $error("generator ran while disabled");
  a_wr_rd_back: assert property (@(posedge sys_clk) // R2
    disable iff (rst) wr && host_req.addr == TX_HI_ADDR
    |=> tx_pattern_high_q == $past(host_req.wdata))
    else $error("transmit high register missed a write");

endmodule : inband_loop_code_regs

/* loop_line_partner.sv */
// Far-end line equipment model: sends a repeating loop code on
// the receive bit stream, one bit every 2 clocks or every 3 when slow.
`timescale 1ns/1ps
module loop_line_partner (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        send,
  input  wire logic        slow,
  input  wire logic [15:0] pattern,
  input  wire logic [4:0]  len,
  output logic             rx_bit_strobe,
  output logic             rx_bit
);
  logic [1:0] gap_q;
  logic [4:0] idx_q;

  // Code bits leave msb first and wrap after len; with no code the
  // line toggles, so it never looks like a steady pattern
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_q         <= 2'h0;
      idx_q         <= 5'h00;
      rx_bit_strobe <= 1'b0;
      rx_bit        <= 1'b0;
    end else if (gap_q == (slow ? 2'h2 : 2'h1)) begin
      gap_q         <= 2'h0;
      rx_bit_strobe <= 1'b1;
      rx_bit        <= send ? pattern[4'hf - idx_q[3:0]] : ~rx_bit;
      idx_q         <= (idx_q + 5'h01 >= len) ? 5'h00 : idx_q + 5'h01;
    end else begin
      gap_q         <= gap_q + 2'h1;
      rx_bit_strobe <= 1'b0;
    end
  end
endmodule : loop_line_partner

/* inband_loop_code_regs_test.sv */
// Self-checking bench for the in-band loop code registers.
// Assumes the partner model drives the receive bit stream.
`timescale 1ns/1ps
module inband_loop_code_regs_test;
  import inband_loop_pkg::*;
  // Short window keeps the run small; limits are fixed at 10 errors and 80 matches
  localparam int WIN = 300;
  localparam logic [15:0] TXP = 16'hb56c;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  host_req_type host_req = '0;
  logic [7:0]   rd_data_q;
  logic         t1_mode = 1'b1;
  logic         tx_loopcode_enable = 1'b0;
  logic         fbit_insert_disable = 1'b1;
  logic         tx_bit_strobe = 1'b0;
  logic         tx_fbit_value = 1'b0;
  logic         tx_data_q, tx_code_active_q, rx_bit_strobe, rx_bit;
  logic         up_code_seen_flag, down_code_seen_flag;
  logic         third_code_seen_flag;
  logic         p_send = 1'b0;
  logic         p_slow = 1'b0;
  logic [15:0]  p_pat = 16'h0000;
  logic [4:0]   p_len = 5'd1;
  int           num_errors = 0;
  int           checked = 0;
  int           cycle_cnt = 0;

  always #2 sys_clk = ~sys_clk;

  inband_loop_code_regs #(.INTEG_CYCLES(WIN), .MAX_ERR(10),
    .MIN_MATCH(80)) u_dut (.sys_clk, .rst, .host_req, .rd_data_q,
    .t1_mode, .tx_loopcode_enable, .fbit_insert_disable, .tx_bit_strobe,
    .tx_fbit_value, .tx_data_q, .tx_code_active_q, .rx_bit_strobe,
    .rx_bit, .up_code_seen_flag, .down_code_seen_flag,
    .third_code_seen_flag);

  loop_line_partner u_line (.sys_clk, .rst, .send(p_send),
    .slow(p_slow), .pattern(p_pat), .len(p_len), .rx_bit_strobe,
    .rx_bit);

  // ------------------------------------------------------------
  // Access and checking tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    host_req <= {1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    host_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    host_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    host_req <= '0;
    #1 d = rd_data_q;
  endtask : rd

  // One strobe; the bit is settled one cycle after its edge
  task automatic tx_bit(output logic b);
    @(posedge sys_clk);
    tx_bit_strobe <= 1'b1;
    @(posedge sys_clk);
    tx_bit_strobe <= 1'b0;
    #1 b = tx_data_q;
  endtask : tx_bit

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard: the whole sequence needs well under 8000 cycles
  always @(posedge sys_clk) begin
    cycle_cnt++;
    if (cycle_cnt == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] v;
    logic [7:0] r;
    logic       b;
    int         l;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, readback, unmapped place at 0xc0
    for (int a = 'hb6; a <= 'hc0; a++) begin
      rd(a[7:0], r);
      check("reset value", r, 8'h00);
      v = (a == 'hbd) ? 8'h05 : a[7:0] ^ 8'h5a;
      wr(a[7:0], v);
      rd(a[7:0], r);
      check("readback", r, (a == 'hc0) ? 8'h00 : v);
    end
    $display("test registers done");
    // Every length code; ignored bits are set so misuse shows
    wr(TX_HI_ADDR, TXP[15:8]);
    wr(TX_LO_ADDR, TXP[7:0]);
    for (int c = 0; c < 4; c++) begin
      l = (c == 0) ? 5 : (c == 1) ? 6 : (c == 2) ? 7 : 16;
      wr(CTRL_ADDR, {c[1:0], 6'h00});
      tx_loopcode_enable <= 1'b1;
      for (int i = 0; i < 2 * l + 1; i++) begin
        tx_bit(b);
        check("tx bit", b, TXP[15 - (i % l)]);
      end
      @(posedge sys_clk);
      tx_loopcode_enable <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 check("tx active", tx_code_active_q, 1'b0);
    end
    // Framing bit overwrite once per 193 bits
    wr(TX_HI_ADDR, 8'h00);
    wr(TX_LO_ADDR, 8'h00);
    @(posedge sys_clk);
    fbit_insert_disable <= 1'b0;
    tx_fbit_value <= 1'b1;
    tx_loopcode_enable <= 1'b1;
    for (int i = 0; i < 195; i++) begin
      tx_bit(b);
      check("framing bit", b, (i % 193) == 0);
    end
    @(posedge sys_clk);
    tx_loopcode_enable <= 1'b0;
    $display("test transmit done");
    // Up and spare code 10000 with their ignored bits all set
    wr(CTRL_ADDR, 8'h20);
    wr(UP_LO_ADDR, 8'hff);
    wr(UP_HI_ADDR, 8'h87);
    wr(DN_LO_ADDR, 8'hff);
    wr(DN_HI_ADDR, 8'h00);
    wr(EX_LEN_ADDR, 8'h04);
    wr(EX_LO_ADDR, 8'hff);
    wr(EX_HI_ADDR, 8'h87);
    @(posedge sys_clk);
    p_pat <= 16'h8000;
    p_len <= 5'd5;
    p_send <= 1'b1;
    repeat (3 * WIN + 10) @(posedge sys_clk);
    #1 check("up flag", up_code_seen_flag, 1'b1);
    check("down flag", down_code_seen_flag, 1'b0);
    check("spare flag", third_code_seen_flag, 1'b1);
    // Sixteen bit code, slow line, down and spare both armed
    @(posedge sys_clk);
    p_pat <= 16'h3c3c;
    p_len <= 5'd16;
    p_slow <= 1'b1;
    wr(CTRL_ADDR, 8'h27);
    wr(DN_LO_ADDR, 8'h3c);
    wr(DN_HI_ADDR, 8'h3c);
    wr(EX_LEN_ADDR, 8'h07);
    wr(EX_LO_ADDR, 8'h3c);
    wr(EX_HI_ADDR, 8'h3c);
    repeat (3 * WIN + 10) @(posedge sys_clk);
    #1 check("up flag", up_code_seen_flag, 1'b0);
    check("down flag", down_code_seen_flag, 1'b1);
    check("spare flag", third_code_seen_flag, 1'b1);
    $display("test detectors done");
    // Leaving T1 mode stops everything
    @(posedge sys_clk);
    t1_mode <= 1'b0;
    tx_loopcode_enable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 check("tx active", tx_code_active_q, 1'b0);
    check("down flag", down_code_seen_flag, 1'b0);
    check("spare flag", third_code_seen_flag, 1'b0);
    $display("test mode done");
    wrap_up();
  end
endmodule : inband_loop_code_regs_test
